// File: hdl/headend_ranging.sv
`timescale 1ns/1ns
module headend_ranging #(
  parameter int IM_PERIOD = ranging_pkg::IM_PERIOD_CYC,
  parameter int RSP_TIME = ranging_pkg::RSP_TIME_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  ranging_link_if.headend link,
  input wire logic ranged_ok_in,
  output logic poll_active_out,
  output logic [13:0] polled_sid_out,
  output logic eq_judged_out
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_HOLD = 3'b010,
    H_POLL = 3'b100
  } hstate_t;
  typedef struct packed {
    hstate_t st;
    logic [15:0] im_cnt;
    logic [15:0] hold_cnt;
    logic [7:0] pend_cnt;
    logic [13:0] next_sid;
    logic [13:0] poll_sid;
    logic map_valid;
    logic [13:0] map_sid;
    logic map_initial;
    logic rsp_valid;
    logic [13:0] rsp_sid;
    logic [7:0] rsp_adj;
    logic rsp_success;
    logic dci_rsp;
    logic eq_judged;
    logic poll_active;
  } hreg_t;
  hreg_t r;
  hreg_t next_r;

  always_comb begin
    next_r = r;
    next_r.map_valid = 1'b0;
    next_r.rsp_valid = 1'b0;
    next_r.dci_rsp = 1'b0;
    next_r.eq_judged = 1'b0;
    if (r.pend_cnt != 8'h00) begin
      next_r.pend_cnt = r.pend_cnt - 8'h01;
    end
    if (r.im_cnt == 16'(IM_PERIOD - 1)) begin
      next_r.im_cnt = 16'h0000;
      next_r.map_valid = 1'b1;
      next_r.map_initial = 1'b1;
      next_r.map_sid = ranging_pkg::SID_BCAST;
    end else begin
      next_r.im_cnt = r.im_cnt + 16'h0001;
    end
    if (link.req_valid && link.req_kind == ranging_pkg::MSG_DCI) begin
      next_r.dci_rsp = 1'b1;
    end else if (link.req_valid && link.req_sid == ranging_pkg::SID_ZERO) begin
      next_r.poll_sid = r.next_sid;
      next_r.next_sid = r.next_sid + 14'h0001;
      next_r.rsp_valid = 1'b1;
      next_r.rsp_sid = r.next_sid;
      next_r.rsp_adj = 8'h00;
      next_r.rsp_success = 1'b0;
      next_r.pend_cnt = link.req_pending;
      next_r.hold_cnt = 16'h0000;
      next_r.st = H_HOLD;
    end else if (link.req_valid && link.req_sid == r.poll_sid && r.st == H_POLL) begin
      next_r.rsp_valid = 1'b1;
      next_r.rsp_sid = r.poll_sid;
      next_r.rsp_adj = 8'h00;
      next_r.rsp_success = ranged_ok_in && r.pend_cnt == 8'h00;
      next_r.eq_judged = r.pend_cnt == 8'h00;
      next_r.pend_cnt = link.req_pending;
      next_r.hold_cnt = 16'h0000;
      next_r.st = next_r.rsp_success ? H_IDLE : H_HOLD;
    end else begin
      case (r.st)
        H_HOLD: begin
          next_r.hold_cnt = r.hold_cnt + 16'h0001;
          if (r.hold_cnt >= 16'(RSP_TIME - 1) && r.pend_cnt == 8'h00
              && r.im_cnt != 16'(IM_PERIOD - 1)) begin
            next_r.map_valid = 1'b1;
            next_r.map_initial = 1'b0;
            next_r.map_sid = r.poll_sid;
            next_r.st = H_POLL;
          end
        end
        default: begin
        end
      endcase
    end
    next_r.poll_active = next_r.st == H_POLL;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      r <= '0;
      r.st <= H_IDLE;
      r.next_sid <= ranging_pkg::SID_FIRST_TEMP;
    end else begin
      r <= next_r;
    end
  end

  assign link.map_valid = r.map_valid;
  assign link.map_sid = r.map_sid;
  assign link.map_initial = r.map_initial;
  assign link.rsp_valid = r.rsp_valid;
  assign link.rsp_sid = r.rsp_sid;
  assign link.rsp_pwr_adj = r.rsp_adj;
  assign link.rsp_chan = 8'h00;
  assign link.rsp_success = r.rsp_success;
  assign link.dci_rsp_valid = r.dci_rsp;
  assign poll_active_out = r.poll_active;
  assign polled_sid_out = r.poll_sid;
  assign eq_judged_out = r.eq_judged;
endmodule

// File: hdl/modem_ranging.sv
`timescale 1ns/1ns
module modem_ranging #(
  parameter int RSP_WAIT = ranging_pkg::RSP_WAIT_CYC,
  parameter int DCI_BASE = ranging_pkg::DCI_BASE_CYC,
  parameter logic [7:0] NUM_CHAN = 8'h04,
  parameter logic [7:0] MAX_TRIES = 8'h10
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  ranging_link_if.modem link,
  input wire logic start_in,
  input wire logic nv_pwr_valid_in,
  input wire logic [7:0] nv_pwr_in,
  input wire logic dci_enable_in,
  input wire logic [7:0] pending_in,
  output logic [7:0] tx_power_out,
  output logic [13:0] sid_out,
  output logic [7:0] up_chan_out,
  output logic ranged_out,
  output logic rescan_out
);
  typedef enum logic [5:0] {
    M_IDLE = 6'b000001,
    M_WAIT_IM = 6'b000010,
    M_WAIT_RSP = 6'b000100,
    M_WAIT_POLL = 6'b001000,
    M_DCI = 6'b010000,
    M_DONE = 6'b100000
  } mstate_t;
  // The whole modem state is one flop image; the comb block fills its next copy.
  typedef struct packed {
    mstate_t st;
    logic [7:0] pwr;
    logic [13:0] sid;
    logic [7:0] chan;
    logic [7:0] tries;
    logic [15:0] tmo;
    logic [2:0] shift;
    logic req_valid;
    logic [1:0] req_kind;
    logic [13:0] req_sid;
    logic ranged;
    logic rescan;
  } mreg_t;
  mreg_t r;
  mreg_t next_r;

  // The 9-bit sum puts both an overflow and a negative result in its top bit.
  // A negative result also sets bit 7, which an overflow above the ceiling cannot.
  function automatic logic [7:0] clamp_pwr(input logic [8:0] v);
    if (v[8] && v[7]) begin
      clamp_pwr = ranging_pkg::PWR_MIN;
    end else if (v[8] || v[7:0] > ranging_pkg::PWR_MAX) begin
      clamp_pwr = ranging_pkg::PWR_MAX;
    end else if (v[7:0] < ranging_pkg::PWR_MIN) begin
      clamp_pwr = ranging_pkg::PWR_MIN;
    end else begin
      clamp_pwr = v[7:0];
    end
  endfunction

  // A stored level is trusted only after it is clamped into range.
  function automatic logic [7:0] start_pwr(input logic ok, input logic [7:0] p);
    start_pwr = ok ? clamp_pwr({1'b0, p}) : ranging_pkg::PWR_MIN;
  endfunction

  // Applies the signed step of a ranging answer, held inside the power range.
  function automatic logic [7:0] adjust_pwr(input logic [7:0] p, input logic [7:0] step);
    logic [8:0] s;
    s = 9'({1'b0, p} + {step[7], step});
    adjust_pwr = clamp_pwr(s);
  endfunction

  always_comb begin
    logic [8:0] sum;
    sum = 9'h000;
    next_r = r;
    next_r.req_valid = 1'b0;
    next_r.rescan = 1'b0;
    // One shared countdown serves both the ranging answer wait and the class retry.
    if (r.tmo != 16'h0000) begin
      next_r.tmo = r.tmo - 16'h0001;
    end
    case (r.st)
      M_IDLE: begin
        // A start pulse picks the stored power level when it is marked valid.
        if (start_in) begin
          next_r.pwr = start_pwr(nv_pwr_valid_in, nv_pwr_in);
          next_r.tries = 8'h00;
          next_r.st = M_WAIT_IM;
        end
      end
      M_WAIT_IM: begin
        // Only a broadcast opportunity may carry the contention request.
        if (link.map_valid && link.map_initial) begin
          next_r.req_valid = 1'b1;
          next_r.req_kind = ranging_pkg::MSG_REQ;
          next_r.req_sid = ranging_pkg::SID_ZERO;
          next_r.tmo = 16'(RSP_WAIT);
          next_r.st = M_WAIT_RSP;
        end
      end
      M_WAIT_RSP: begin
        if (link.rsp_valid) begin
          next_r.sid = link.rsp_sid;
          next_r.chan = link.rsp_chan;
          next_r.pwr = adjust_pwr(r.pwr, link.rsp_pwr_adj);
          next_r.st = M_WAIT_POLL;
        end else if (r.tmo == 16'h0000) begin
          sum = 9'({1'b0, r.pwr} + {1'b0, ranging_pkg::PWR_STEP_UP});
          // Overshoot past the ceiling restarts the sweep from the bottom.
          next_r.pwr = (sum > {1'b0, ranging_pkg::PWR_MAX}) ? ranging_pkg::PWR_MIN
                       : sum[7:0];
          next_r.tries = r.tries + 8'h01;
          next_r.st = M_WAIT_IM;
          // The last try on a channel moves on and restarts power from its start level.
          if (r.tries == MAX_TRIES - 8'h01) begin
            next_r.tries = 8'h00;
            next_r.pwr = start_pwr(nv_pwr_valid_in, nv_pwr_in);
            if (r.chan == NUM_CHAN - 8'h01) begin
              next_r.chan = 8'h00;
              next_r.rescan = 1'b1;
              next_r.st = M_IDLE;
            end else begin
              next_r.chan = r.chan + 8'h01;
            end
          end
        end
      end
      M_WAIT_POLL: begin
        // A poll for another modem, or a broadcast opportunity, is ignored here.
        if (link.rsp_valid && link.rsp_sid == r.sid) begin
          next_r.pwr = adjust_pwr(r.pwr, link.rsp_pwr_adj);
          if (link.rsp_success) begin
            next_r.ranged = 1'b1;
            next_r.shift = 3'h0;
            next_r.tmo = 16'h0000;
            next_r.st = dci_enable_in ? M_DCI : M_DONE;
          end
        end else if (link.map_valid && !link.map_initial && link.map_sid == r.sid) begin
          next_r.req_valid = 1'b1;
          next_r.req_kind = ranging_pkg::MSG_REQ;
          next_r.req_sid = r.sid;
        end
      end
      M_DCI: begin
        // The retry wait doubles after every unanswered request, up to a fixed cap.
        if (link.dci_rsp_valid) begin
          next_r.st = M_DONE;
        end else if (r.tmo == 16'h0000) begin
          next_r.req_valid = 1'b1;
          next_r.req_kind = ranging_pkg::MSG_DCI;
          next_r.req_sid = r.sid;
          next_r.tmo = 16'(DCI_BASE << r.shift);
          if (r.shift != 3'(ranging_pkg::DCI_MAX_SHIFT)) begin
            next_r.shift = r.shift + 3'h1;
          end
        end
      end
      default: begin
      end
    endcase
  end

  // Reset parks the transmitter at the bottom of its power range.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      r <= '0;
      r.st <= M_IDLE;
      r.pwr <= ranging_pkg::PWR_MIN;
    end else begin
      r <= next_r;
    end
  end

  // The pending count rides beside the request without a register of its own.
  assign link.req_valid = r.req_valid;
  assign link.req_kind = r.req_kind;
  assign link.req_sid = r.req_sid;
  assign link.req_pending = pending_in;
  assign tx_power_out = r.pwr;
  assign sid_out = r.sid;
  assign up_chan_out = r.chan;
  assign ranged_out = r.ranged;
  assign rescan_out = r.rescan;
endmodule

// File: hdl/ranging_link_if.sv
`timescale 1ns/1ns
interface ranging_link_if;
  logic map_valid;
  logic [13:0] map_sid;
  logic map_initial;
  logic req_valid;
  logic [1:0] req_kind;
  logic [13:0] req_sid;
  logic [7:0] req_pending;
  logic rsp_valid;
  logic [13:0] rsp_sid;
  logic signed [7:0] rsp_pwr_adj;
  logic [7:0] rsp_chan;
  logic rsp_success;
  logic dci_rsp_valid;
  modport headend (
    output map_valid, map_sid, map_initial, rsp_valid, rsp_sid, rsp_pwr_adj,
    output rsp_chan, rsp_success, dci_rsp_valid,
    input req_valid, req_kind, req_sid, req_pending
  );
  modport modem (
    input map_valid, map_sid, map_initial, rsp_valid, rsp_sid, rsp_pwr_adj,
    input rsp_chan, rsp_success, dci_rsp_valid,
    output req_valid, req_kind, req_sid, req_pending
  );
endinterface

// File: hdl/ranging_pkg.sv
package ranging_pkg;
  localparam int SID_W = 14;
  localparam int PWR_W = 8;
  localparam int CH_W = 8;
  localparam logic [13:0] SID_ZERO = 14'h0000;
  localparam logic [13:0] SID_BCAST = 14'h3fff;
  localparam logic [13:0] SID_FIRST_TEMP = 14'h0001;
  localparam logic [7:0] PWR_MIN = 8'h08;
  localparam logic [7:0] PWR_MAX = 8'hf0;
  localparam logic [7:0] PWR_STEP_UP = 8'h04;
  localparam int RSP_TIME_US = 1;
  localparam int CLK_MHZ = 100;
  localparam int RSP_TIME_CYC = RSP_TIME_US * CLK_MHZ;
  localparam int IM_PERIOD_CYC = 200;
  localparam int RSP_WAIT_CYC = 400;
  localparam int DCI_BASE_CYC = 64;
  localparam int DCI_MAX_SHIFT = 4;
  localparam int CNT_W = 16;
  localparam logic [1:0] MSG_NONE = 2'h0;
  localparam logic [1:0] MSG_REQ = 2'h1;
  localparam logic [1:0] MSG_DCI = 2'h2;
endpackage

// File: tb/ranging_asserts.sv
`timescale 1ns/1ns
module ranging_asserts #(
  parameter int IM_PERIOD = ranging_pkg::IM_PERIOD_CYC,
  parameter int RSP_TIME = ranging_pkg::RSP_TIME_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic map_valid,
  input wire logic [13:0] map_sid,
  input wire logic map_initial,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [13:0] req_sid,
  input wire logic rsp_valid,
  input wire logic [13:0] rsp_sid,
  input wire logic dci_rsp_valid
);
  int im_cnt;
  int rsp_cnt;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Cycles since the last broadcast map and since the last ranging answer.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || (map_valid && map_initial)) begin
      im_cnt <= 0;
    end else begin
      im_cnt <= im_cnt + 1;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || rsp_valid) begin
      rsp_cnt <= 0;
    end else if (rsp_cnt < 1000) begin
      rsp_cnt <= rsp_cnt + 1;
    end
  end
  broadcast_sid_a: assert property (
    map_valid && map_initial |-> map_sid == ranging_pkg::SID_BCAST) else $error("map sid");
  contention_zero_a: assert property (
    map_valid && map_initial ##1 req_valid && req_kind == ranging_pkg::MSG_REQ
    |-> req_sid == ranging_pkg::SID_ZERO) else $error("contention sid");
  temp_sid_a: assert property (
    req_valid && req_kind == ranging_pkg::MSG_REQ && req_sid == ranging_pkg::SID_ZERO
    |=> rsp_valid && rsp_sid != ranging_pkg::SID_ZERO) else $error("no temporary sid");
  poll_answer_a: assert property (
    req_valid && req_kind == ranging_pkg::MSG_REQ && req_sid != ranging_pkg::SID_ZERO
    |=> rsp_valid && rsp_sid == $past(req_sid)) else $error("poll not answered");
  poll_reply_a: assert property (
    map_valid && !map_initial |=> req_valid && req_sid == $past(map_sid)) else $error("poll");
  im_period_a: assert property (im_cnt <= IM_PERIOD) else $error("broadcast gap");
  rsp_time_a: assert property (
    map_valid && !map_initial |-> rsp_cnt >= RSP_TIME - 1) else $error("poll too soon");
  dci_reply_a: assert property (
    req_valid && req_kind == ranging_pkg::MSG_DCI |-> ##[1:2] dci_rsp_valid) else $error("dci");
endmodule

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic start_in = 1'b0;
  logic nv_v = 1'b0;
  logic [7:0] nv_p = 8'h00;
  logic dci_en = 1'b0;
  logic [7:0] pend = 8'h00;
  logic ok_in = 1'b1;
  logic nv_v2 = 1'b1;
  logic [7:0] nv_p2 = 8'he8;
  logic dci_en2 = 1'b0;
  logic [7:0] pend2 = 8'h00;
  logic [7:0] pwr;
  logic [7:0] pwr2;
  logic [7:0] chan;
  logic [13:0] sid;
  logic ranged;
  logic rescan2;
  logic rescan1;
  logic poll_act;
  logic [13:0] psid;
  logic eq_judged;
  logic [7:0] chan2;
  logic [13:0] sid2;
  logic ranged2;
  logic rescan1_seen;
  logic poll_seen;
  logic eq_seen;
  logic dci_seen;
  logic [7:0] seen_pend;
  logic [7:0] pw2 [$];
  logic [7:0] ch2 [$];
  logic [7:0] exp_pw [5] = '{8'he8, 8'hec, 8'hf0, ranging_pkg::PWR_MIN, 8'he8};
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_req = 0;
  int t_poll = 0;
  int n_req2 = 0;
  localparam int IM_P = 20;
  localparam int RSP_T = 5;
  localparam int WAIT_C = 40;
  localparam int DCI_B = 8;
  localparam logic [7:0] N_CH = 8'h02;
  localparam logic [7:0] M_TRY = 8'h04;
  ranging_link_if lk ();
  ranging_link_if lk2 ();
  always #5 sys_clk_in = ~sys_clk_in;
  headend_ranging #(.IM_PERIOD(IM_P), .RSP_TIME(RSP_T)) headend_ranging_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .link(lk), .ranged_ok_in(ok_in),
    .poll_active_out(poll_act), .polled_sid_out(psid), .eq_judged_out(eq_judged));
  modem_ranging #(.RSP_WAIT(WAIT_C), .DCI_BASE(DCI_B), .NUM_CHAN(N_CH), .MAX_TRIES(M_TRY))
    modem_ranging_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .link(lk),
    .start_in(start_in), .nv_pwr_valid_in(nv_v), .nv_pwr_in(nv_p), .dci_enable_in(dci_en),
    .pending_in(pend), .tx_power_out(pwr), .sid_out(sid), .up_chan_out(chan),
    .ranged_out(ranged), .rescan_out(rescan1));
  // Second modem faces a headend that never answers.
  modem_ranging #(.RSP_WAIT(WAIT_C), .DCI_BASE(DCI_B), .NUM_CHAN(N_CH), .MAX_TRIES(M_TRY))
    modem_ranging_inst2 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .link(lk2),
    .start_in(start_in), .nv_pwr_valid_in(nv_v2), .nv_pwr_in(nv_p2), .dci_enable_in(dci_en2),
    .pending_in(pend2), .tx_power_out(pwr2), .sid_out(sid2), .up_chan_out(chan2),
    .ranged_out(ranged2), .rescan_out(rescan2));
  ranging_asserts #(.IM_PERIOD(IM_P), .RSP_TIME(RSP_T)) ranging_asserts_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .map_valid(lk.map_valid),
    .map_sid(lk.map_sid), .map_initial(lk.map_initial), .req_valid(lk.req_valid),
    .req_kind(lk.req_kind), .req_sid(lk.req_sid), .rsp_valid(lk.rsp_valid),
    .rsp_sid(lk.rsp_sid), .dci_rsp_valid(lk.dci_rsp_valid));
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    lk2.map_valid <= (cyc % IM_P == 0);
    if (lk.req_valid && lk.req_sid == ranging_pkg::SID_ZERO) begin
      t_req = cyc;
      seen_pend = lk.req_pending;
    end
    if (lk.map_valid && !lk.map_initial && t_poll <= t_req) t_poll = cyc;
    if (lk.dci_rsp_valid) dci_seen = 1'b1;
    if (eq_judged) eq_seen = 1'b1;
    if (poll_act) poll_seen = 1'b1;
    if (rescan1) rescan1_seen = 1'b1;
    if (lk2.req_valid) begin
      n_req2++;
      pw2.push_back(pwr2);
      ch2.push_back(chan2);
    end
    if (cyc > 8000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic do_reset();
    @(posedge sys_clk_in);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    n_req2 = 0;
    pw2.delete();
    t_req = 0;
    t_poll = 0;
    dci_seen = 1'b0;
    ch2.delete();
    eq_seen = 1'b0;
    poll_seen = 1'b0;
    rescan1_seen = 1'b0;
  endtask
  task automatic go();
    @(posedge sys_clk_in);
    start_in <= 1'b1;
    @(posedge sys_clk_in);
    start_in <= 1'b0;
    for (int i = 0; i < 600 && ranged !== 1'b1; i++) @(posedge sys_clk_in);
  endtask
  task automatic t_noanswer();
    do_reset();
    go();
    for (int i = 0; i < 2000 && rescan2 !== 1'b1; i++) @(posedge sys_clk_in);
    chk(n_req2 == 8, "tries before rescan");
    foreach (exp_pw[i]) chk(pw2[i] === exp_pw[i], "power step");
    foreach (pw2[i]) chk(pw2[i] >= 8'h08 && pw2[i] <= 8'hf0, "power range");
    chk(ch2[3] === 8'h00 && ch2[4] === 8'h01, "next upstream channel");
    chk(chan2 === 8'h00 && ranged2 === 1'b0 && sid2 === 14'h0000, "rescan state");
  endtask
  task automatic t_plain();
    do_reset();
    go();
    chk(ranged === 1'b1, "not ranged");
    chk(sid === ranging_pkg::SID_FIRST_TEMP, "temporary sid");
    chk(pwr === ranging_pkg::PWR_MIN, "start power");
    chk(chan === 8'h00, "upstream channel");
    chk(psid === ranging_pkg::SID_FIRST_TEMP, "polled sid");
    chk(poll_seen === 1'b1 && poll_act === 1'b0, "poll cycle");
    chk(eq_seen === 1'b1, "equalization judged");
    chk(rescan1_seen === 1'b0, "spurious rescan");
  endtask
  task automatic t_nv_retry();
    nv_v <= 1'b1;
    nv_p <= 8'h40;
    ok_in <= 1'b0;
    do_reset();
    go();
    chk(ranged === 1'b0, "ranged out of tolerance");
    ok_in <= 1'b1;
    go();
    chk(ranged === 1'b1 && pwr === 8'h40, "stored power");
    nv_v <= 1'b0;
  endtask
  task automatic t_pending();
    pend <= 8'h1e;
    do_reset();
    go();
    chk(seen_pend === 8'h1e, "pending value");
    chk(t_poll - t_req >= 30, "poll held off");
    pend <= 8'h00;
  endtask
  task automatic t_dci();
    dci_en <= 1'b1;
    do_reset();
    go();
    repeat (200) @(posedge sys_clk_in);
    chk(dci_seen === 1'b1, "device class answer");
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    lk2.map_initial = 1'b1;
    lk2.map_sid = ranging_pkg::SID_BCAST;
    lk2.rsp_valid = 1'b0;
    lk2.rsp_sid = 14'h0000;
    lk2.rsp_pwr_adj = 8'sh00;
    lk2.rsp_chan = 8'h00;
    lk2.rsp_success = 1'b0;
    lk2.dci_rsp_valid = 1'b0;
    t_noanswer();
    t_plain();
    t_nv_retry();
    t_pending();
    t_dci();
    end_sim();
  end
endmodule
